/* rtl/iacch_defines.vh */
// Constants for the integrating converter conversion handshake
`ifndef IACCH_DEFINES_VH
`define IACCH_DEFINES_VH
`define IACCH_CLK_NS          10
`define IACCH_CONV_MAX_US     4000
`define IACCH_CONV_MAX_CYC    (`IACCH_CONV_MAX_US * 1000 / `IACCH_CLK_NS)
`define IACCH_INTEG_US        640
`define IACCH_INTEG_CYC       (`IACCH_INTEG_US * 1000 / `IACCH_CLK_NS)
`define IACCH_PAUSE_US        10
`define IACCH_PAUSE_CYC       (`IACCH_PAUSE_US * 1000 / `IACCH_CLK_NS)
`define IACCH_SLACK_CYC       100
`define IACCH_DATA_W          16
`define IACCH_HI_BIT          8
`define IACCH_CNT_W           20
`endif

/* rtl/iacch_sync.v */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module iacch_sync (
    input  wire clock_i,
    input  wire rstn_i,
    input  wire pin_i,
    output reg  sync_o
);
    reg meta_reg;
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_reg <= 1'b1;
            sync_o   <= 1'b1;
        end else begin
            meta_reg <= pin_i;
            sync_o   <= meta_reg;
        end
    end
endmodule

/* rtl/iacch_top.v */
// Conversion sequencer and output handshake of the integrating converter
`timescale 1ns/1ps
`include "iacch_defines.vh"
module iacch_top (
    input  wire        clock_i,
    input  wire        rstn_i,
    input  wire        trigger_n_i,
    input  wire        cmp_pos_i,
    input  wire        cmp_done_i,
    output reg  [15:0] result_o,
    output reg         sign_o,
    output reg         sign_n_o,
    output wire        busy_o,
    output reg  [2:0]  phase_o,
    output wire        auto_zero_phase_o
);
    localparam [2:0] ST_AZ    = 3'h0;
    localparam [2:0] ST_INTEG = 3'h1;
    localparam [2:0] ST_PAUSE = 3'h2;
    localparam [2:0] ST_REFHI = 3'h3;
    localparam [2:0] ST_PAUS2 = 3'h4;
    localparam [2:0] ST_REFLO = 3'h5;

    // One reference budget shared by both slopes
    localparam integer INTEG_I   = `IACCH_INTEG_CYC;
    localparam integer PAUSE_I   = `IACCH_PAUSE_CYC;
    localparam integer LIMIT_I   = `IACCH_CONV_MAX_CYC - 2 * `IACCH_PAUSE_CYC
                                   - `IACCH_INTEG_CYC - `IACCH_SLACK_CYC;
    localparam [19:0]  INTEG_CYC = INTEG_I[19:0];
    localparam [19:0]  PAUSE_CYC = PAUSE_I[19:0];
    localparam [19:0]  LIMIT_CYC = LIMIT_I[19:0];
    localparam [16:0] HI_STEP   = 17'h00100;
    localparam [16:0] LO_STEP   = 17'h00001;

    reg         rst_meta_reg;
    reg         rst_reg;
    wire        rstn_sync;
    wire        trig_sync;
    reg         trig_last_reg;
    reg  [2:0]  state_reg;
    reg  [2:0]  state_next;
    reg  [19:0] timer_reg;
    reg  [19:0] ref_time_reg;
    reg  [16:0] count_reg;
    reg         pol_reg;
    reg         busy_reg;
    reg         armed_reg;
    wire        trig_fall;
    wire        trig_rise;
    wire        timer_hit;
    wire        ref_over;

    function [16:0] iacch_sat_add;
        input [16:0] a;
        input [16:0] b;
        reg   [17:0] s;
        begin
            s = {1'b0, a} + {1'b0, b};
            iacch_sat_add = s[17] ? 17'h0ffff :
                            ((s[16:0] > 17'h0ffff) ? 17'h0ffff : s[16:0]);
        end
    endfunction

    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_meta_reg <= 1'b0;
            rst_reg      <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_reg      <= rst_meta_reg;
        end
    end
    assign rstn_sync = rst_reg;

    iacch_sync u_trig_sync (
        .clock_i (clock_i),
        .rstn_i  (rstn_sync),
        .pin_i   (trigger_n_i),
        .sync_o  (trig_sync)
    );

    // Edge detect on synchronised trigger; 0.1 us pulse spans 10 clocks
    assign trig_fall = trig_last_reg & ~trig_sync;
    assign trig_rise = ~trig_last_reg & trig_sync;
    assign timer_hit = (timer_reg == 20'h00001) || (timer_reg == 20'h00000);
    assign ref_over  = (ref_time_reg >= LIMIT_CYC);
    assign busy_o    = busy_reg;
    assign auto_zero_phase_o = (state_reg == ST_AZ);

    // Phase sequencer
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_AZ: begin
                if (trig_rise && armed_reg) begin
                    state_next = ST_INTEG;
                end
            end
            ST_INTEG: begin
                if (timer_hit) begin
                    state_next = ST_PAUSE;
                end
            end
            ST_PAUSE: begin
                if (timer_hit) begin
                    state_next = ST_REFHI;
                end
            end
            ST_REFHI: begin
                if (cmp_done_i || ref_over) begin
                    state_next = ST_PAUS2;
                end
            end
            ST_PAUS2: begin
                if (timer_hit) begin
                    state_next = ST_REFLO;
                end
            end
            ST_REFLO: begin
                if (cmp_done_i || ref_over) begin
                    state_next = ST_AZ;
                end
            end
            default: begin
                state_next = ST_AZ;
            end
        endcase
    end

    always @(posedge clock_i or negedge rstn_sync) begin
        if (!rstn_sync) begin
            state_reg     <= ST_AZ;
            trig_last_reg <= 1'b1;
            timer_reg     <= 20'h00000;
            ref_time_reg  <= 20'h00000;
            count_reg     <= 17'h00000;
            pol_reg       <= 1'b0;
            busy_reg      <= 1'b0;
            armed_reg     <= 1'b0;
            result_o      <= 16'h0000;
            sign_o        <= 1'b0;
            sign_n_o      <= 1'b1;
            phase_o       <= 3'h0;
        end else begin
            trig_last_reg <= trig_sync;
            state_reg     <= state_next;
            phase_o       <= state_next;
            if (timer_reg != 20'h00000) begin
                timer_reg <= timer_reg - 20'h00001;
            end
            // Falling edge in standby: clear counters, go busy
            if (trig_fall && state_reg == ST_AZ) begin
                count_reg    <= 17'h00000;
                ref_time_reg <= 20'h00000;
                armed_reg    <= 1'b1;
                busy_reg     <= 1'b1;
            end
            case (state_reg)
                ST_AZ: begin
                    if (trig_rise && armed_reg) begin
                        timer_reg <= INTEG_CYC;
                        armed_reg <= 1'b0;
                    end
                end
                ST_INTEG: begin
                    if (timer_hit) begin
                        pol_reg   <= cmp_pos_i;
                        timer_reg <= PAUSE_CYC;
                    end
                end
                ST_PAUSE: begin
                    if (timer_hit) begin
                        ref_time_reg <= 20'h00000;
                    end
                end
                ST_REFHI: begin
                    ref_time_reg <= ref_time_reg + 20'h00001;
                    if (cmp_done_i || ref_over) begin
                        timer_reg <= PAUSE_CYC;
                    end else begin
                        count_reg <= iacch_sat_add(count_reg, HI_STEP);
                    end
                end
                ST_PAUS2: begin
                    // Budget count runs on into the low slope
                end
                ST_REFLO: begin
                    ref_time_reg <= ref_time_reg + 20'h00001;
                    if (cmp_done_i || ref_over) begin
                        // Publish result and drop busy in the same cycle
                        result_o <= count_reg[15:0];
                        sign_o   <= pol_reg;
                        sign_n_o <= ~pol_reg;
                        busy_reg <= 1'b0;
                    end else begin
                        count_reg <= iacch_sat_add(count_reg, LO_STEP);
                    end
                end
                default: begin
                    timer_reg <= 20'h00000;
                end
            endcase
        end
    end
endmodule

/* dv/iacch_chk.sv */
// Checker for the conversion handshake ports
`timescale 1ns/1ps
module iacch_chk (
    input wire        clock_i,
    input wire        rstn_i,
    input wire        trigger_n_i,
    input wire [15:0] result_o,
    input wire        sign_o,
    input wire        sign_n_o,
    input wire        busy_o,
    input wire [2:0]  phase_o,
    input wire        auto_zero_phase_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    logic [19:0] integ_q;
    logic [19:0] busy_q;
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            integ_q <= 20'h0;
            busy_q <= 20'h0;
        end else begin
            integ_q <= (phase_o == 3'h1) ? integ_q + 20'h1 : 20'h0;
            busy_q <= busy_o ? busy_q + 20'h1 : 20'h0;
        end
    end
    a_sign_pair: assert property (sign_n_o == !sign_o)
        else $error("sign pair broken");
    a_idle_azero: assert property (!busy_o |-> auto_zero_phase_o)
        else $error("idle without autozero");
    a_busy_phase: assert property (phase_o != 3'h0 |-> busy_o)
        else $error("busy low mid conversion");
    a_result_hold: assert property (
        !busy_o && $past(busy_o) == 1'b0 |-> $stable({sign_o, result_o}))
        else $error("result moved while idle");
    a_busy_prompt: assert property (
        $fell(trigger_n_i) && !busy_o |-> ##[1:6] busy_o)
        else $error("busy late");
    a_start_rise: assert property (
        $rose(trigger_n_i) && busy_o && phase_o == 3'h0
        |-> ##[2:5] phase_o == 3'h1)
        else $error("no start on rise");
    a_integ_len: assert property (
        $past(phase_o) == 3'h1 && phase_o != 3'h1 |-> integ_q == 20'd64000)
        else $error("integration length wrong");
    a_phase_step: assert property ($changed(phase_o) |->
        phase_o == $past(phase_o) + 3'h1 || $past(phase_o) == 3'h5)
        else $error("phase order wrong");
    a_valid_end: assert property (
        $fell(busy_o) |-> $past(phase_o) == 3'h5 && phase_o == 3'h0)
        else $error("busy fell early");
    a_conv_budget: assert property (busy_o |-> busy_q < 20'd400000)
        else $error("conversion too long");
    cover property ($rose(busy_o));
    cover property ($fell(busy_o));
    cover property (phase_o == 3'h5);
endmodule
bind iacch_top iacch_chk chk_u (.clock_i, .rstn_i, .trigger_n_i, .result_o,
    .sign_o, .sign_n_o, .busy_o, .phase_o, .auto_zero_phase_o);

/* dv/iacch_host_model.sv */
// Host model issuing conversion requests and reading results
`timescale 1ns/1ps
module iacch_host_model (
    input  wire         clock_i,
    input  wire         go_i,
    input  wire         extra_i,
    input  wire [7:0]   low_len_i,
    input  wire         busy_i,
    input  wire [15:0]  result_i,
    input  wire         sign_i,
    output logic        trigger_n_o,
    output logic        done_o,
    output logic [16:0] data_o
);
    localparam int PACE_CYC = 400000;
    int gap_q = PACE_CYC;
    // Cycles since the last trigger pulse
    always @(posedge clock_i)
        gap_q <= !trigger_n_o ? 0 : gap_q + int'(gap_q < PACE_CYC);
    initial begin
        trigger_n_o = 1'b1;
        done_o = 1'b0;
        data_o = 17'h0;
        forever begin
            @(posedge clock_i);
            if (go_i && gap_q >= PACE_CYC) begin
                trigger_n_o <= 1'b0;
                repeat (low_len_i) @(posedge clock_i);
                trigger_n_o <= 1'b1;
                if (extra_i) begin
                    repeat (300) @(posedge clock_i);
                    trigger_n_o <= 1'b0;
                    repeat (low_len_i) @(posedge clock_i);
                    trigger_n_o <= 1'b1;
                end
                for (int k = 0; k < 80000 && busy_i !== 1'b0; k++)
                    @(posedge clock_i);
                @(posedge clock_i);
                data_o <= {sign_i, result_i};
                done_o <= 1'b1;
                @(posedge clock_i);
                done_o <= 1'b0;
            end
        end
    end
endmodule

/* dv/iacch_tb_top.sv */
// Self-checking bench for the conversion handshake
`timescale 1ns/1ps
module integrating_adc_conversion_handshake_tb_top;
    logic clock_i = 0, rstn_i = 0, cmp_pos_i = 0, cmp_done_i = 0;
    logic go = 0, extra = 0, trig_n;
    logic [7:0] hi_len = 8'd1, lo_len = 8'd1, low_len = 8'd10, cnt = 0;
    wire [15:0] result_o;
    wire [16:0] host_data;
    wire [2:0] phase_o;
    wire sign_o, sign_n_o, busy_o, az_o, host_done;
    int miscompares = 0, comparisons = 0, n1 = 0, n3 = 0, n5 = 0, nb = 0;
    logic [31:0] seed = 32'd22755;
    always #5 clock_i = ~clock_i;
    iacch_top dut_u (.clock_i, .rstn_i, .trigger_n_i(trig_n), .cmp_pos_i,
        .cmp_done_i, .result_o, .sign_o, .sign_n_o, .busy_o, .phase_o,
        .auto_zero_phase_o(az_o));
    iacch_host_model host_u (.clock_i, .go_i(go), .extra_i(extra),
        .low_len_i(low_len), .busy_i(busy_o), .result_i(result_o),
        .sign_i(sign_o), .trigger_n_o(trig_n), .done_o(host_done),
        .data_o(host_data));
    always @(posedge clock_i) begin
        cnt <= (phase_o == 3'h3 || phase_o == 3'h5) ? cnt + 8'h1 : 8'h0;
        cmp_done_i <= (phase_o == 3'h3 && cnt >= hi_len)
            || (phase_o == 3'h5 && cnt >= lo_len);
        n1 <= n1 + int'(phase_o == 3'h1);
        n3 <= n3 + int'(phase_o == 3'h3);
        n5 <= n5 + int'(phase_o == 3'h5);
        nb <= nb + int'(busy_o === 1'b1);
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic near(logic [7:0] s, int n);
        return int'(s) >= n - 1 && int'(s) <= n + 1;
    endfunction
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s exp %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clock_i);
        rstn_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        check("idle", {busy_o, phase_o, az_o}, 32'h1);
        check("sign_n", sign_n_o, !sign_o);
        $display("test reset done");
        hi_len <= 8'd1 + 8'(rnd() % 200);
        lo_len <= 8'd1 + 8'(rnd() % 200);
        low_len <= 8'd10 + 8'(rnd() % 16);
        cmp_pos_i <= 1'(rnd());
        extra <= 1'b1;
        go <= 1'b1;
        @(posedge clock_i);
        go <= 1'b0;
        for (int i = 0; i < 80000 && host_done !== 1'b1; i++)
            @(posedge clock_i);
        if (host_done !== 1'b1) begin
            check("timeout", 1, 0);
        end else begin
            check("sign", sign_o, cmp_pos_i);
            check("sign_n", sign_n_o, !cmp_pos_i);
            check("hi", near(result_o[15:8], n3), 1);
            check("lo", near(result_o[7:0], n5), 1);
            check("host", host_data, {sign_o, result_o});
            check("integ", n1, 64000);
            check("budget", nb <= 400000, 1);
            check("idle", {busy_o, phase_o, az_o}, 32'h1);
            $display("test conversion done");
            repeat (50) @(posedge clock_i);
            check("hold", host_data, {sign_o, result_o});
            $display("test hold done");
        end
        summarize();
    end
endmodule
